// ===== design/odd_regs.vh
// Constants for the output divider and driver configuration slice
`ifndef ODD_REGS_VH
`define ODD_REGS_VH

// Register indexes; byte address is four times the index
`define ODD_IDX_NINTH_DRV 10'h243
`define ODD_IDX_DIV_RATIO 10'h244
`define ODD_IDX_DIV_SRC 10'h245
`define ODD_IDX_TENTH_DRV 10'h246
`define ODD_IDX_DIV_STAT 10'h247

// Reset values
`define ODD_RST_DIV_RATIO 8'h83
`define ODD_RST_DIV_SRC 8'h80
`define ODD_RST_DRV 8'hc1

// Divider register fields
`define ODD_F_RSVD 7
`define ODD_F_PD 6
`define ODD_F_SRC 6
`define ODD_F_VAL_HI 5
`define ODD_F_VAL_LO 0

// Driver register fields
`define ODD_F_SWING 7
`define ODD_F_FMT_HI 6
`define ODD_F_FMT_LO 4
`define ODD_F_POL_HI 3
`define ODD_F_POL_LO 2
`define ODD_F_STR 1
`define ODD_F_EN 0

// Driver format codes
`define ODD_FMT_TRI 3'h0
`define ODD_FMT_HSTL 3'h1
`define ODD_FMT_LVDS 3'h2
`define ODD_FMT_HCSL 3'h3
`define ODD_FMT_CMOS 3'h4
`define ODD_FMT_CMOS_P 3'h5
`define ODD_FMT_CMOS_N 3'h6
`define ODD_FMT_RSVD 3'h7

// AHB transfer type bit that marks an active transfer
`define ODD_HTRANS_ACT 1

`endif

// ===== design/odd_drv.v
// One output driver: format, polarity, swing, strength and enable
`timescale 1ns/1ps
`include "odd_regs.vh"

module odd_drv (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Clock to drive and configuration byte
  input wire src_clk,
  input wire [7:0] cfg,
  // Positive leg
  output reg pos_o,
  output reg pos_oe_n,
  // Negative leg
  output reg neg_o,
  output reg neg_oe_n,
  // Analog controls toward the pad cell
  output reg full_swing,
  output reg cmos_low_drive,
  output reg lvds_high_current
);

  wire [2:0] fmt; // Selected format
  wire [1:0] pol; // CMOS polarity code
  wire en; // Driver powered
  wire is_cmos; // Any CMOS format
  wire pos_inv; // Positive leg inverted
  wire neg_inv; // Negative leg inverted

  assign fmt = cfg[`ODD_F_FMT_HI:`ODD_F_FMT_LO];
  assign pol = cfg[`ODD_F_POL_HI:`ODD_F_POL_LO];
  assign en = cfg[`ODD_F_EN];
  assign is_cmos = (fmt == `ODD_FMT_CMOS) || (fmt == `ODD_FMT_CMOS_P) ||
                   (fmt == `ODD_FMT_CMOS_N);
  // Codes 00,10 leave positive straight; 00,01 invert negative
  assign pos_inv = pol[0];
  assign neg_inv = ~pol[1];

  // Legs registered so the pins never glitch on config writes
  always @(posedge sys_clk) begin
    if (srst) begin
      pos_o <= 1'b0;
      neg_o <= 1'b0;
      pos_oe_n <= 1'b1;
      neg_oe_n <= 1'b1;
      full_swing <= 1'b0;
      cmos_low_drive <= 1'b0;
      lvds_high_current <= 1'b0;
    end else begin
      // Powered down or tristate or reserved: both legs released
      pos_o <= 1'b0;
      neg_o <= 1'b0;
      pos_oe_n <= 1'b1;
      neg_oe_n <= 1'b1;
      if (en) begin
        case (fmt)
          `ODD_FMT_HSTL, `ODD_FMT_LVDS, `ODD_FMT_HCSL: begin
            // Differential pair, fixed true and complement
            pos_o <= src_clk;
            neg_o <= ~src_clk;
            pos_oe_n <= 1'b0;
            neg_oe_n <= 1'b0;
          end
          `ODD_FMT_CMOS: begin
            pos_o <= src_clk ^ pos_inv;
            neg_o <= src_clk ^ neg_inv;
            pos_oe_n <= 1'b0;
            neg_oe_n <= 1'b0;
          end
          `ODD_FMT_CMOS_P: begin
            pos_o <= src_clk ^ pos_inv;
            pos_oe_n <= 1'b0;
          end
          `ODD_FMT_CMOS_N: begin
            neg_o <= src_clk ^ neg_inv;
            neg_oe_n <= 1'b0;
          end
          default: begin
            // Tristate and reserved code keep legs released
            pos_oe_n <= 1'b1;
          end
        endcase
      end
      // Swing only meaningful for CMOS formats
      full_swing <= en & is_cmos & cfg[`ODD_F_SWING];
      // Strength only acts on LVDS or full-swing CMOS
      cmos_low_drive <= en & is_cmos & cfg[`ODD_F_SWING] & cfg[`ODD_F_STR];
      lvds_high_current <= en & (fmt == `ODD_FMT_LVDS) & cfg[`ODD_F_STR];
    end
  end

endmodule // odd_drv

// ===== design/odd_top.v
// Channel divider and ninth/tenth driver configuration with AHB-Lite slave
`timescale 1ns/1ps
`include "odd_regs.vh"

module odd_top #(
  parameter RATIO_W = 6 // Width of ratio and phase fields
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Loop one selected reference, asynchronous pin
  input wire loop_one_ref_in,
  // Ninth driver source from same-clock logic
  input wire ninth_src_clk,
  // Ninth output driver pins
  output wire ninth_pos_o,
  output wire ninth_pos_oe_n,
  output wire ninth_neg_o,
  output wire ninth_neg_oe_n,
  output wire ninth_full_swing,
  output wire ninth_cmos_low_drive,
  output wire ninth_lvds_high_current,
  // Tenth output driver pins
  output wire tenth_pos_o,
  output wire tenth_pos_oe_n,
  output wire tenth_neg_o,
  output wire tenth_neg_oe_n,
  output wire tenth_full_swing,
  output wire tenth_cmos_low_drive,
  output wire tenth_lvds_high_current,
  // Channel divider state
  output wire divider_clk_out,
  output wire divider_running
);

  // Divider states
  localparam ST_OFF = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;

  // Index match on a word-aligned byte address
  function hit;
    input [11:0] addr;
    input [9:0] idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  // Any writable register; unmapped and status offsets excluded
  function is_rw;
    input [11:0] addr;
    begin
      is_rw = hit(addr, `ODD_IDX_NINTH_DRV) || hit(addr, `ODD_IDX_DIV_RATIO) ||
              hit(addr, `ODD_IDX_DIV_SRC) || hit(addr, `ODD_IDX_TENTH_DRV);
    end
  endfunction

  // Register storage
  reg [7:0] ninth_drv_q; // Ninth driver config
  reg [7:0] div_ratio_q; // Reserved, power-down, ratio
  reg [7:0] div_src_q; // Reserved, source, phase
  reg [7:0] tenth_drv_q; // Tenth driver config

  // Bus data-phase bookkeeping
  reg wr_pend_q; // Write data due this cycle
  reg [11:0] wr_addr_q; // Address of pending write
  reg [7:0] rd_byte; // Read mux result
  wire bus_act; // Address phase accepted
  wire [7:0] wr_byte; // Low byte of write data

  // Divider state
  reg [1:0] st_q; // Divider state
  reg [1:0] st_d;
  reg [RATIO_W+1:0] cnt_q; // Position within output period
  reg [RATIO_W+1:0] cnt_d;
  reg [RATIO_W-1:0] dly_q; // Remaining phase delay
  reg [RATIO_W-1:0] dly_d;
  reg div_clk_q; // Divided clock
  reg div_clk_d;
  reg restart_q; // Ratio or phase rewritten

  // Reference synchroniser
  reg ref_meta_q; // First stage only feeds second
  reg ref_sync_q; // Safe to use

  wire pd; // Divider power-down
  wire [RATIO_W-1:0] ratio; // Ratio field
  wire [RATIO_W-1:0] phase; // Phase offset field
  wire [RATIO_W:0] half; // Input half periods per half output
  wire [RATIO_W+1:0] period; // Half periods per output period
  wire tenth_src; // Chosen tenth output clock

  // Always zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_act = hsel & hready & htrans[`ODD_HTRANS_ACT];
  assign wr_byte = hwdata[7:0];

  // Capture write address phase; data arrives next cycle
  always @(posedge sys_clk) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= bus_act & hwrite;
      wr_addr_q <= haddr[11:0];
    end
  end

  // Register writes in the data phase
  always @(posedge sys_clk) begin
    if (srst) begin
      // Reset values hold until written
      ninth_drv_q <= `ODD_RST_DRV;
      div_ratio_q <= `ODD_RST_DIV_RATIO;
      div_src_q <= `ODD_RST_DIV_SRC;
      tenth_drv_q <= `ODD_RST_DRV;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      if (wr_pend_q) begin
        // Reserved top bits stored as written; software keeps them one
        if (hit(wr_addr_q, `ODD_IDX_NINTH_DRV)) begin
          ninth_drv_q <= wr_byte;
        end
        if (hit(wr_addr_q, `ODD_IDX_DIV_RATIO)) begin
          div_ratio_q <= wr_byte;
          restart_q <= 1'b1;
        end
        if (hit(wr_addr_q, `ODD_IDX_DIV_SRC)) begin
          div_src_q <= wr_byte;
          restart_q <= 1'b1;
        end
        if (hit(wr_addr_q, `ODD_IDX_TENTH_DRV)) begin
          tenth_drv_q <= wr_byte;
        end
      end
    end
  end

  // Read mux; forwards a write that lands in the same cycle
  always @* begin
    rd_byte = 8'h00;
    if (hit(haddr[11:0], `ODD_IDX_NINTH_DRV)) begin
      rd_byte = ninth_drv_q;
    end else if (hit(haddr[11:0], `ODD_IDX_DIV_RATIO)) begin
      rd_byte = div_ratio_q;
    end else if (hit(haddr[11:0], `ODD_IDX_DIV_SRC)) begin
      rd_byte = div_src_q;
    end else if (hit(haddr[11:0], `ODD_IDX_TENTH_DRV)) begin
      rd_byte = tenth_drv_q;
    end else if (hit(haddr[11:0], `ODD_IDX_DIV_STAT)) begin
      // Live divider state
      rd_byte = {5'h00, div_clk_q, st_q};
    end
    // Back-to-back write then read of one register; unmapped writes
    // are dropped, so forwarding them would read back a phantom value
    if (wr_pend_q && (wr_addr_q == haddr[11:0]) && is_rw(haddr[11:0])) begin
      rd_byte = wr_byte;
    end
  end

  // Read data registered at address phase, valid in data phase
  always @(posedge sys_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (bus_act && !hwrite) begin
      // Unmapped addresses read as zero
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // Field extraction
  assign pd = div_ratio_q[`ODD_F_PD];
  assign ratio = div_ratio_q[`ODD_F_VAL_HI:`ODD_F_VAL_LO];
  assign phase = div_src_q[`ODD_F_VAL_HI:`ODD_F_VAL_LO];
  // Each sys_clk cycle stands for one half period of the divider input
  assign half = {1'b0, ratio} + {{RATIO_W{1'b0}}, 1'b1};
  assign period = {half, 1'b0};

  // Divider next state
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    dly_d = dly_q;
    case (st_q)
      ST_OFF: begin
        // Held stopped while powered down
        cnt_d = {(RATIO_W+2){1'b0}};
        if (!pd) begin
          st_d = ST_WAIT;
          dly_d = phase;
        end
      end
      ST_WAIT: begin
        // Static phase: delay start by phase half periods
        if (pd) begin
          st_d = ST_OFF;
        end else if (restart_q) begin
          dly_d = phase;
        end else if (dly_q == {RATIO_W{1'b0}}) begin
          st_d = ST_RUN;
          cnt_d = {(RATIO_W+2){1'b0}};
        end else begin
          dly_d = dly_q - {{(RATIO_W-1){1'b0}}, 1'b1};
        end
      end
      ST_RUN: begin
        if (pd) begin
          st_d = ST_OFF;
        end else if (restart_q) begin
          // Resync so new ratio and phase align cleanly
          st_d = ST_WAIT;
          dly_d = phase;
        end else if (cnt_q >= period - {{(RATIO_W+1){1'b0}}, 1'b1}) begin
          cnt_d = {(RATIO_W+2){1'b0}};
        end else begin
          cnt_d = cnt_q + {{(RATIO_W+1){1'b0}}, 1'b1};
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    // High for the first half of the output period
    div_clk_d = (st_d == ST_RUN) && (cnt_d < {1'b0, half});
  end

  // Divider registers
  always @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_OFF;
      cnt_q <= {(RATIO_W+2){1'b0}};
      dly_q <= {RATIO_W{1'b0}};
      div_clk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dly_q <= dly_d;
      div_clk_q <= div_clk_d;
    end
  end

  // Two-stage synchroniser for the asynchronous reference
  always @(posedge sys_clk) begin
    if (srst) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
    end else begin
      ref_meta_q <= loop_one_ref_in;
      ref_sync_q <= ref_meta_q;
    end
  end

  // Tenth output source select
  // Reference path lags the divider path by the two synchroniser cycles
  assign tenth_src = div_src_q[`ODD_F_SRC] ? ref_sync_q : div_clk_q;

  assign divider_clk_out = div_clk_q;
  assign divider_running = (st_q == ST_RUN);

  // Ninth output driver
  odd_drv u_ninth (
    .sys_clk(sys_clk),
    .srst(srst),
    .src_clk(ninth_src_clk),
    .cfg(ninth_drv_q),
    .pos_o(ninth_pos_o),
    .pos_oe_n(ninth_pos_oe_n),
    .neg_o(ninth_neg_o),
    .neg_oe_n(ninth_neg_oe_n),
    .full_swing(ninth_full_swing),
    .cmos_low_drive(ninth_cmos_low_drive),
    .lvds_high_current(ninth_lvds_high_current)
  );

  // Tenth output driver
  odd_drv u_tenth (
    .sys_clk(sys_clk),
    .srst(srst),
    .src_clk(tenth_src),
    .cfg(tenth_drv_q),
    .pos_o(tenth_pos_o),
    .pos_oe_n(tenth_pos_oe_n),
    .neg_o(tenth_neg_o),
    .neg_oe_n(tenth_neg_oe_n),
    .full_swing(tenth_full_swing),
    .cmos_low_drive(tenth_cmos_low_drive),
    .lvds_high_current(tenth_lvds_high_current)
  );

endmodule // odd_top

// ===== verification/odd_rx.sv
// Receiver on the tenth output and loop reference source
`timescale 1ns/1ps
module odd_rx (
  // Receiver side
  input wire rx_pos,
  input wire clr,
  output reg [15:0] edges,
  // Reference toward the loop path
  output reg ref_clk
);
  // Free running reference, phase unrelated to the system clock
  initial ref_clk = 1'b0;
  always #215 ref_clk = ~ref_clk;
  // Rising edges seen on the positive leg
  always @(posedge rx_pos or posedge clr) begin
    if (clr)
      edges <= 16'h0000;
    else
      edges <= edges + 16'h0001;
  end
endmodule // odd_rx

// ===== verification/odd_top_asserts.sv
// Checker on the divider and tenth driver ports
`timescale 1ns/1ps
module odd_chk (
  // Clock, reset and bus
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Tenth driver and divider
  input wire tenth_pos_o,
  input wire tenth_pos_oe_n,
  input wire tenth_neg_o,
  input wire tenth_neg_oe_n,
  input wire tenth_full_swing,
  input wire tenth_cmos_low_drive,
  input wire tenth_lvds_high_current,
  input wire divider_clk_out,
  input wire divider_running
);
  reg w_q; // Write data phase
  reg [11:0] a_q; // Its address
  reg [6:0] hi_q; // High cycles while running
  reg [5:0] r_q; // Last ratio written
  reg dirty_q; // Restart pending, period stale
  wire wdiv = w_q && a_q[11:3] == 9'h122; // Ratio or phase write
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Track divider writes and time each high phase
  always @(posedge sys_clk) begin
    w_q <= hsel && hready && htrans[1] && hwrite && !srst;
    a_q <= haddr[11:0];
    hi_q <= (divider_running && divider_clk_out) ? hi_q + 7'h01 : 7'h00;
    if (srst)
      r_q <= 6'h03;
    else if (wdiv && !a_q[2])
      r_q <= hwdata[5:0];
    if (srst || wdiv)
      dirty_q <= !srst;
    else if (!divider_running)
      dirty_q <= 1'b0;
  end
  AST_RST_OUT: assert property ($fell(srst) |-> !divider_running && tenth_pos_oe_n)
    else $error("outputs not idle after reset");
  AST_SWING: assert property (tenth_full_swing |-> !(tenth_pos_oe_n && tenth_neg_oe_n))
    else $error("full swing with no leg driven");
  AST_LOW_DRV: assert property (tenth_cmos_low_drive |-> tenth_full_swing)
    else $error("low drive outside full swing");
  AST_LVDS_CUR: assert property (tenth_lvds_high_current |-> !tenth_full_swing)
    else $error("current and swing both set");
  AST_LVDS_LEGS: assert property (tenth_lvds_high_current |-> tenth_pos_o != tenth_neg_o)
    else $error("differential legs equal");
  AST_DIV_HIGH: assert property ($fell(divider_clk_out) && $past(divider_running) && !dirty_q
    |-> hi_q == {1'b0, r_q} + 7'h01) else $error("divider high time wrong");
  AST_PWR_DOWN: assert property (wdiv && !a_q[2] && hwdata[6]
    |-> ##[1:3] !divider_running && !divider_clk_out) else $error("divider still running");
  AST_DRV_OFF: assert property (w_q && a_q == 12'h918 && !hwdata[0]
    |-> ##[1:3] tenth_pos_oe_n && tenth_neg_oe_n) else $error("driver not powered down");
endmodule // odd_chk

bind odd_top odd_chk u_odd_chk (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .tenth_pos_o(tenth_pos_o), .tenth_pos_oe_n(tenth_pos_oe_n), .tenth_neg_o(tenth_neg_o),
  .tenth_neg_oe_n(tenth_neg_oe_n), .tenth_full_swing(tenth_full_swing),
  .tenth_cmos_low_drive(tenth_cmos_low_drive),
  .tenth_lvds_high_current(tenth_lvds_high_current),
  .divider_clk_out(divider_clk_out), .divider_running(divider_running));

// ===== verification/tb_odd_top.sv
// Bench for the divider and driver slice
`timescale 1ns/1ps
module tb_odd_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg nsrc = 1'b0; // Ninth source clock
  reg clr = 1'b1; // Clears receiver count
  reg rdp = 1'b0; // Read data phase
  reg [31:0] s = 32'h40d4; // Random state
  reg [31:0] q[$]; // Expected read data
  reg [5:0] r;
  reg [2:0] f;
  reg [1:0] e;
  reg [1:0] p; // Expected leg inversions {positive, negative}
  reg d; // Divider clock one cycle earlier
  integer fails = 0;
  integer n_checks = 0;
  integer i, h, l, c;
  wire hready, t_p, t_poe, t_n, t_noe, t_fs, t_ld, t_lh, dclk, drun, rclk;
  wire [31:0] hrdata;
  wire [15:0] edges;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  // Ninth source follows random bits
  always @(posedge sys_clk) nsrc <= nsrc ^ s[0];
  odd_top u_odd_top (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(), .hrdata(hrdata), .loop_one_ref_in(rclk),
    .ninth_src_clk(nsrc), .ninth_pos_o(), .ninth_pos_oe_n(), .ninth_neg_o(),
    .ninth_neg_oe_n(), .ninth_full_swing(), .ninth_cmos_low_drive(),
    .ninth_lvds_high_current(), .tenth_pos_o(t_p), .tenth_pos_oe_n(t_poe),
    .tenth_neg_o(t_n), .tenth_neg_oe_n(t_noe), .tenth_full_swing(t_fs),
    .tenth_cmos_low_drive(t_ld), .tenth_lvds_high_current(t_lh),
    .divider_clk_out(dclk), .divider_running(drun));
  odd_rx u_odd_rx (.rx_pos(t_p), .clr(clr), .edges(edges), .ref_clk(rclk));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // One bus phase, bounded wait for ready
  task hw;
    integer n;
    begin
      n = 0;
      do begin
        @(posedge sys_clk);
        n = n + 1;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
        fails = fails + 1;
        close_out;
      end
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hw;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      hw;
    end
  endtask
  task rd(input [31:0] a, input [31:0] x);
    begin
      q.push_back(x);
      bus(1'b0, a, 32'h0);
    end
  endtask
  // Count cycles while running (sel) or clock holds v
  task wt(input sel, input v, output integer n);
    begin
      n = 0;
      while ((sel ? drun : dclk) === v && n < 300) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (n >= 300) begin
        fails = fails + 1;
        close_out;
      end
    end
  endtask
  // Read data checked against oldest note
  always @(posedge sys_clk) begin
    if (rdp)
      chk(hrdata, q.pop_front());
    rdp <= hsel && hready && htrans[1] && !hwrite;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails = fails + 1;
    close_out;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    clr <= 1'b0;
    rd(32'h90c, 32'hc1);
    rd(32'h910, 32'h83);
    rd(32'h914, 32'h80);
    rd(32'h918, 32'hc1);
    rd(32'h920, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      s = xs(s);
      bus(1'b1, 32'h90c, s);
      rd(32'h90c, {24'h0, s[7:0]});
    end
    $display("registers done");
    for (i = 0; i < 3; i = i + 1) begin
      s = xs(s);
      r = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : s[5:0];
      bus(1'b1, 32'h910, {26'h2, r});
      wt(1'b0, 1'b1, c);
      wt(1'b0, 1'b0, c);
      wt(1'b0, 1'b1, h);
      wt(1'b0, 1'b0, l);
      wt(1'b0, 1'b1, h);
      wt(1'b0, 1'b0, l);
      chk(h, r + 1);
      chk(l, r + 1);
    end
    bus(1'b1, 32'h910, 32'hc3);
    repeat (4) @(negedge sys_clk);
    chk({30'h0, drun, dclk}, 32'h0);
    rd(32'h91c, 32'h0);
    bus(1'b1, 32'h910, 32'h83);
    for (i = 0; i < 2; i = i + 1) begin
      s = xs(s);
      r = i ? s[5:0] : 6'h00;
      bus(1'b1, 32'h914, {26'h2, r});
      wt(1'b1, 1'b1, c);
      wt(1'b1, 1'b0, c);
      if (i)
        chk(c - h, r);
      h = c;
    end
    $display("divider done");
    for (i = 0; i < 2; i = i + 1) begin
      bus(1'b1, 32'h910, 32'hbf);
      bus(1'b1, 32'h914, i ? 32'h80 : 32'hc0);
      repeat (20) @(negedge sys_clk);
      clr <= 1'b1;
      @(negedge sys_clk);
      clr <= 1'b0;
      repeat (400) @(negedge sys_clk);
      chk({31'h0, edges > 16'h1e}, {31'h0, i == 0});
    end
    $display("source done");
    bus(1'b1, 32'h910, 32'h83);
    for (i = 0; i < 8; i = i + 1) begin
      f = i[2:0];
      bus(1'b1, 32'h918, {24'h0, f == 3'h5, f, 4'h3});
      repeat (3) @(negedge sys_clk);
      e = (f == 3'h0 || f == 3'h7) ? 2'h3 : (f == 3'h5) ? 2'h1 : (f == 3'h6) ? 2'h2 : 2'h0;
      chk({30'h0, t_poe, t_noe}, {30'h0, e});
      chk({29'h0, t_fs, t_ld, t_lh}, {29'h0, f == 3'h5, f == 3'h5, f == 3'h2});
    end
    for (i = 0; i < 4; i = i + 1) begin
      e = i[1:0];
      // Polarity table: 00 P straight N inverted, 01 both inverted,
      // 10 both straight, 11 P inverted N straight
      p = (e == 2'h0) ? 2'h1 : (e == 2'h1) ? 2'h3 : (e == 2'h2) ? 2'h0 : 2'h2;
      bus(1'b1, 32'h918, {24'h0, 4'hc, e, 2'h1});
      repeat (3) @(negedge sys_clk);
      // Legs lag the divider clock by one cycle; cover both levels
      for (c = 0; c < 8; c = c + 1) begin
        d = dclk;
        @(negedge sys_clk);
        chk({30'h0, t_p, t_n}, {30'h0, d ^ p[1], d ^ p[0]});
      end
    end
    bus(1'b1, 32'h918, 32'hc0);
    repeat (3) @(negedge sys_clk);
    chk({30'h0, t_poe, t_noe}, 32'h3);
    // Reset in mid-run restores the reset configuration
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rd(32'h918, 32'hc1);
    repeat (3) @(negedge sys_clk);
    chk({30'h0, t_poe, t_noe}, 32'h0);
    $display("drivers done");
    close_out;
  end
endmodule // tb_odd_top
